// file: i2cib_core.sv
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module i2cib_core (
	input  wire logic       clk,            // System clock, 100 MHz
	input  wire logic       rst,            // Async reset, active high
	// Register port
	input  wire logic [3:0] reg_addr,       // Register index
	input  wire logic [7:0] reg_wdata,      // Write data
	input  wire logic       reg_wr,         // Write strobe
	input  wire logic       reg_rd,         // Read strobe
	output logic      [7:0] reg_rdata,      // Read data, cycle after strobe
	// Transfer engine side (same clock)
	input  wire logic       eng_scl_low,    // Engine drives SCL low
	input  wire logic       eng_shift_take, // Pulse: shifter takes tx byte
	input  wire logic       eng_tx_done,    // Pulse: byte sent, shifter empty
	input  wire logic       eng_rx_done,    // Pulse: byte received
	input  wire logic [7:0] eng_rx_byte,    // Received byte
	input  wire logic       eng_eighth_fall,// Pulse: eighth clock falls
	input  wire logic       eng_eighth_rise,// Pulse: eighth clock rises
	input  wire logic       eng_nack,       // Pulse: NACK received
	input  wire logic       eng_stop,       // Pulse: stop recognised
	input  wire logic       eng_arb_lost,   // Pulse: arbitration lost
	output logic      [7:0] tx_shift_data,  // Byte handed to the shifter
	output logic            tx_data_valid,  // Byte waiting for the shifter
	output logic            master_select,  // Master mode
	output logic            transmit_select,// Transmit mode
	output logic            i2c_mode,       // 1 I2C, 0 clock synchronous
	output logic            single_byte_receive_ctrl, // Byte-wise receive
	output logic            scl_high_seen,  // Pulse: SCL high after release
	output logic            scl_sync_wait,  // Bit synchronisation pending
	// SCL pad
	input  wire logic       scl_in,         // SCL pin level
	output logic            scl_out,        // SCL output value, always low
	output logic            scl_oe,         // High while pulling SCL low
	// Interrupts
	output logic            tx_empty_irq,   // Transmit-empty request
	output logic            tx_end_irq,     // Transmit-end request
	output logic            rx_full_irq,    // Receive-full request
	output logic            stop_seen_irq,  // Stop recognition request
	output logic            nack_irq,       // NACK / lost / overrun request
	output logic            irq             // Combined masked interrupt
);

	// ************************************************************
	// Declarations
	// ************************************************************
	logic [7:0]             bus_mode_reg;
	logic [7:0]             ctrl_reg;
	logic [7:0]             irq_en;
	logic [7:0]             tx_data_reg;
	logic [7:0]             rx_data_reg;
	logic [4:0]             evt_status;
	logic [4:0]             evt_mask;
	logic [4:0]             req_now;
	logic [4:0]             req_prev;
	logic                   tx_empty_flag;
	logic                   tx_end_flag;
	logic                   rx_full_flag;
	logic                   nack_flag;
	logic                   stop_flag;
	logic                   arb_lost_overrun_flag;
	logic                   scl_hold_low;
	logic                   scl_drive_prev;
	logic                   scl_drive;
	logic                   scl_level;
	logic                   wr_ctrl;
	logic                   wr_status;
	logic                   wr_tx;
	logic                   rd_rx;
	logic                   rd_evt;
	logic                   master_rx;
	logic                   overrun;
	logic                   rx_accept;
	logic [7:0]             status_view;
	logic [7:0]             next_rdata;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
		hit = (a == r);
	endfunction

	assign wr_ctrl   = reg_wr && hit(reg_addr, i2cib_pkg::REG_CTRL);
	assign wr_status = reg_wr && hit(reg_addr, i2cib_pkg::REG_STATUS);
	assign wr_tx     = reg_wr && hit(reg_addr, i2cib_pkg::REG_TX_DATA);
	assign rd_rx     = reg_rd && hit(reg_addr, i2cib_pkg::REG_RX_DATA);
	assign rd_evt    = reg_rd && hit(reg_addr, i2cib_pkg::REG_EVT_STAT);

	assign master_select            = ctrl_reg[i2cib_pkg::CTRL_MST];
	assign transmit_select          = ctrl_reg[i2cib_pkg::CTRL_TRS];
	assign single_byte_receive_ctrl = ctrl_reg[i2cib_pkg::CTRL_SINGLE_BYTE_RECEIVE_CTRL];
	assign i2c_mode                 = bus_mode_reg[i2cib_pkg::MODE_I2C];
	assign master_rx = master_select && !transmit_select && i2c_mode;

	// ************************************************************
	// Configuration registers
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_mode_reg <= i2cib_pkg::MODE_RST;
			irq_en       <= i2cib_pkg::IRQ_EN_RST;
			evt_mask     <= i2cib_pkg::EVT_MASK_RST[4:0];
		end else if (reg_wr) begin
			if (hit(reg_addr, i2cib_pkg::REG_MODE)) begin
				bus_mode_reg <= reg_wdata;
			end
			if (hit(reg_addr, i2cib_pkg::REG_IRQ_EN)) begin
				irq_en <= reg_wdata;
			end
			if (hit(reg_addr, i2cib_pkg::REG_EVT_MASK)) begin
				evt_mask <= reg_wdata[4:0];
			end
		end
	end

	// Arbitration loss drops master and transmit; hardware wins over a write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= i2cib_pkg::CTRL_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg <= reg_wdata;
			end
			if (eng_arb_lost) begin
				ctrl_reg[i2cib_pkg::CTRL_MST] <= 1'b0;
				ctrl_reg[i2cib_pkg::CTRL_TRS] <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Transmit path
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_data_reg   <= i2cib_pkg::ZERO_BYTE;
			tx_shift_data <= i2cib_pkg::ZERO_BYTE;
			tx_data_valid <= 1'b0;
		end else begin
			if (wr_tx) begin
				tx_data_reg   <= reg_wdata;
				tx_data_valid <= 1'b1;
			end else if (tx_data_valid && eng_shift_take) begin
				tx_shift_data <= tx_data_reg;
				tx_data_valid <= 1'b0;
			end
		end
	end

	// Set beats a status-write clear, a data write beats set; software clearing empty by hand risks a spare byte
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_empty_flag <= 1'b0;
			tx_end_flag   <= 1'b0;
		end else begin
			if (wr_status && !reg_wdata[i2cib_pkg::ST_TX_EMPTY]) begin
				tx_empty_flag <= 1'b0;
			end
			if (wr_status && !reg_wdata[i2cib_pkg::ST_TX_END]) begin
				tx_end_flag <= 1'b0;
			end
			if (wr_tx) begin
				tx_empty_flag <= 1'b0;
				tx_end_flag   <= 1'b0;
			end else begin
				if (tx_data_valid && eng_shift_take) begin
					tx_empty_flag <= 1'b1;
				end
				if (eng_tx_done && tx_empty_flag && !tx_data_valid) begin
					tx_end_flag <= 1'b1;
				end
			end
		end
	end

	// ************************************************************
	// Receive path
	// ************************************************************
	// Clock-sync overrun: the old byte stays put
	assign overrun   = !i2c_mode && eng_eighth_rise && rx_full_flag;
	assign rx_accept = eng_rx_done && !(rx_full_flag && !i2c_mode && !rd_rx);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_data_reg  <= i2cib_pkg::ZERO_BYTE;
			rx_full_flag <= 1'b0;
		end else begin
			if (rd_rx) begin
				rx_full_flag <= 1'b0;
			end
			if (rx_accept) begin
				rx_data_reg  <= eng_rx_byte;
				rx_full_flag <= 1'b1;
			end
		end
	end

	// ************************************************************
	// Event flags cleared by writing zero
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nack_flag             <= 1'b0;
			stop_flag             <= 1'b0;
			arb_lost_overrun_flag <= 1'b0;
		end else begin
			if (wr_status) begin
				nack_flag <= reg_wdata[i2cib_pkg::ST_NACK] & nack_flag;
				stop_flag <= reg_wdata[i2cib_pkg::ST_STOP] & stop_flag;
				arb_lost_overrun_flag <=
					reg_wdata[i2cib_pkg::ST_ALO] & arb_lost_overrun_flag;
			end
			if (eng_nack) begin
				nack_flag <= 1'b1;
			end
			if (eng_stop) begin
				stop_flag <= 1'b1;
			end
			if (eng_arb_lost || overrun) begin
				arb_lost_overrun_flag <= 1'b1;
			end
		end
	end

	// ************************************************************
	// SCL hold and bit synchronisation
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_hold_low <= 1'b0;
		end else begin
			if (!master_rx || rd_rx || !rx_full_flag) begin
				scl_hold_low <= 1'b0;
			end else if (eng_eighth_fall) begin
				scl_hold_low <= 1'b1;
			end
		end
	end

	assign scl_drive = eng_scl_low || scl_hold_low;
	assign scl_oe    = scl_drive;
	assign scl_out   = 1'b0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_drive_prev <= 1'b0;
		end else begin
			scl_drive_prev <= scl_drive;
		end
	end

	i2cib_scl_monitor u_mon (
		.clk         (clk),
		.rst         (rst),
		.scl_pin     (scl_in),
		.release_pls (scl_drive_prev && !scl_drive),
		.enable      (master_select),
		.rate_sel    ({ctrl_reg[i2cib_pkg::CTRL_RATE3],
		               ctrl_reg[i2cib_pkg::CTRL_RATE2]}),
		.scl_level   (scl_level),
		.high_seen   (scl_high_seen),
		.sync_wait   (scl_sync_wait)
	);

	// ************************************************************
	// Interrupt requests: levels of flag and enable; stop and NACK also need I2C mode
	// ************************************************************
	assign tx_empty_irq  = tx_empty_flag
		&& irq_en[i2cib_pkg::ST_TX_EMPTY];
	assign tx_end_irq    = tx_end_flag && irq_en[i2cib_pkg::ST_TX_END];
	assign rx_full_irq   = rx_full_flag && irq_en[i2cib_pkg::ST_RX_FULL];
	assign stop_seen_irq = stop_flag && i2c_mode
		&& irq_en[i2cib_pkg::ST_STOP];
	// Lost/overrun stays live in clock-sync mode; NACK does not
	assign nack_irq = ((nack_flag && i2c_mode) || arb_lost_overrun_flag)
		&& irq_en[i2cib_pkg::ST_NACK];

	assign req_now = {nack_irq, stop_seen_irq, rx_full_irq,
	                  tx_end_irq, tx_empty_irq};

	// Sticky capture of each request's rising edge; read clears, set wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			req_prev   <= '0;
			evt_status <= '0;
		end else begin
			req_prev   <= req_now;
			evt_status <= (rd_evt ? 5'h00 : evt_status)
				| (req_now & ~req_prev);
		end
	end

	assign irq = |(evt_status & evt_mask);

	// ************************************************************
	// Read mux, data one cycle after the strobe
	// ************************************************************
	always_comb begin
		status_view = i2cib_pkg::ZERO_BYTE;
		status_view[i2cib_pkg::ST_TX_EMPTY] = tx_empty_flag;
		status_view[i2cib_pkg::ST_TX_END]   = tx_end_flag;
		status_view[i2cib_pkg::ST_RX_FULL]  = rx_full_flag;
		status_view[i2cib_pkg::ST_NACK]     = nack_flag;
		status_view[i2cib_pkg::ST_STOP]     = stop_flag;
		status_view[i2cib_pkg::ST_ALO]      = arb_lost_overrun_flag;
		next_rdata = i2cib_pkg::ZERO_BYTE;
		unique case (reg_addr)
			i2cib_pkg::REG_MODE:     next_rdata = bus_mode_reg;
			i2cib_pkg::REG_CTRL:     next_rdata = ctrl_reg;
			i2cib_pkg::REG_CTRL2: begin
				next_rdata[i2cib_pkg::CTRL2_SCL_LEVEL_MONITOR_BIT]      = scl_level;
				next_rdata[i2cib_pkg::CTRL2_SYNC_WAIT] = scl_sync_wait;
			end
			i2cib_pkg::REG_IRQ_EN:   next_rdata = irq_en;
			i2cib_pkg::REG_STATUS:   next_rdata = status_view;
			i2cib_pkg::REG_TX_DATA:  next_rdata = tx_data_reg;
			i2cib_pkg::REG_RX_DATA:  next_rdata = rx_data_reg;
			i2cib_pkg::REG_EVT_STAT: next_rdata = {3'h0, evt_status};
			i2cib_pkg::REG_EVT_MASK: next_rdata = {3'h0, evt_mask};
			default:                 next_rdata = i2cib_pkg::ZERO_BYTE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= i2cib_pkg::ZERO_BYTE;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= i2cib_pkg::ZERO_BYTE;
		end
	end

endmodule

// file: i2cib_pkg.sv
package i2cib_pkg;

	// ************************************************************
	// Register map (byte index on the plain register port)
	// ************************************************************
	localparam int             ADDR_W          = 4;
	localparam int             DATA_W          = 8;
	localparam logic [3:0]     REG_MODE        = 4'h0;
	localparam logic [3:0]     REG_CTRL        = 4'h1;
	localparam logic [3:0]     REG_CTRL2       = 4'h2;
	localparam logic [3:0]     REG_IRQ_EN      = 4'h3;
	localparam logic [3:0]     REG_STATUS      = 4'h4;
	localparam logic [3:0]     REG_TX_DATA     = 4'h5;
	localparam logic [3:0]     REG_RX_DATA     = 4'h6;
	localparam logic [3:0]     REG_EVT_STAT    = 4'h7;
	localparam logic [3:0]     REG_EVT_MASK    = 4'h8;

	// ************************************************************
	// Field positions
	// ************************************************************
	// bus_mode_reg
	localparam int             MODE_I2C        = 0;
	localparam int             MODE_WAIT       = 1;
	// control register
	localparam int             CTRL_MST        = 0;
	localparam int             CTRL_TRS        = 1;
	localparam int             CTRL_RATE2      = 2;
	localparam int             CTRL_RATE3      = 3;
	localparam int             CTRL_SINGLE_BYTE_RECEIVE_CTRL       = 4;
	// bus_control_reg_two
	localparam int             CTRL2_SCL_LEVEL_MONITOR_BIT      = 0;
	localparam int             CTRL2_SYNC_WAIT = 1;
	// bus_status_reg and irq enables share one layout
	localparam int             ST_TX_EMPTY     = 0;
	localparam int             ST_TX_END       = 1;
	localparam int             ST_RX_FULL      = 2;
	localparam int             ST_NACK         = 3;
	localparam int             ST_STOP         = 4;
	localparam int             ST_ALO          = 5;
	// Event status / mask: one bit per request line
	localparam int             EV_TXI          = 0;
	localparam int             EV_TEI          = 1;
	localparam int             EV_RXI          = 2;
	localparam int             EV_STOP_SEEN_IRQ         = 3;
	localparam int             EV_NACK_IRQ         = 4;
	localparam int             NUM_EV          = 5;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0]     MODE_RST        = 8'h01;
	localparam logic [7:0]     CTRL_RST        = 8'h00;
	localparam logic [7:0]     IRQ_EN_RST      = 8'h00;
	localparam logic [7:0]     EVT_MASK_RST    = 8'h00;
	localparam logic [7:0]     ZERO_BYTE       = 8'h00;

	// ************************************************************
	// SCL monitor delay after release, in system clock periods
	// ************************************************************
	localparam real            MON_T00_TCYC    = 7.5;
	localparam real            MON_T01_TCYC    = 19.5;
	localparam real            MON_T10_TCYC    = 17.5;
	localparam real            MON_T11_TCYC    = 41.5;
	localparam int             MON_W           = 6;
	// Least times round up to whole cycles
	localparam logic [5:0]     MON_C00 = 6'($rtoi(MON_T00_TCYC + 0.999));
	localparam logic [5:0]     MON_C01 = 6'($rtoi(MON_T01_TCYC + 0.999));
	localparam logic [5:0]     MON_C10 = 6'($rtoi(MON_T10_TCYC + 0.999));
	localparam logic [5:0]     MON_C11 = 6'($rtoi(MON_T11_TCYC + 0.999));
	localparam logic [5:0]     MON_ONE = 6'h01;

	typedef enum logic [1:0] {
		MON_IDLE  = 2'b00,
		MON_DELAY = 2'b01,
		MON_WAIT  = 2'b10
	} i2cib_mon_e;

	function automatic logic [5:0] mon_cycles(input logic [1:0] sel);
		unique case (sel)
			2'b00: mon_cycles = MON_C00;
			2'b01: mon_cycles = MON_C01;
			2'b10: mon_cycles = MON_C10;
			2'b11: mon_cycles = MON_C11;
		endcase
	endfunction

endpackage

// file: i2cib_scl_monitor.sv
`timescale 1ns/1ps
module i2cib_scl_monitor (
	input  wire logic       clk,          // System clock
	input  wire logic       rst,          // Async reset, active high
	input  wire logic       scl_pin,      // Raw SCL level from the pad
	input  wire logic       release_pls,  // SCL output went low to released
	input  wire logic       enable,       // Master mode: monitoring active
	input  wire logic [1:0] rate_sel,     // rate_sel_bit3, rate_sel_bit2
	output logic            scl_level,    // Synchronised SCL level
	output logic            high_seen,    // Pulse: SCL seen high after delay
	output logic            sync_wait     // Waiting for SCL to go high
);

	logic                   scl_meta;
	logic [5:0]             count;
	i2cib_pkg::i2cib_mon_e  state;

	// ************************************************************
	// Synchroniser: only the second stage is read by logic
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_meta  <= 1'b1;
			scl_level <= 1'b1;
		end else begin
			scl_meta  <= scl_pin;
			scl_level <= scl_meta;
		end
	end

	// ************************************************************
	// Delay then sample; a stretched or slow SCL holds the bit
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state     <= i2cib_pkg::MON_IDLE;
			count     <= '0;
			high_seen <= 1'b0;
		end else begin
			high_seen <= 1'b0;
			if (!enable) begin
				state <= i2cib_pkg::MON_IDLE;
			end else begin
				unique case (state)
					i2cib_pkg::MON_IDLE: begin
						if (release_pls) begin
							count <= i2cib_pkg::mon_cycles(rate_sel);
							state <= i2cib_pkg::MON_DELAY;
						end
					end
					i2cib_pkg::MON_DELAY: begin
						if (count == i2cib_pkg::MON_ONE) begin
							state <= i2cib_pkg::MON_WAIT;
						end
						count <= count - i2cib_pkg::MON_ONE;
					end
					i2cib_pkg::MON_WAIT: begin
						// High period counts from the observed high level
						if (scl_level) begin
							high_seen <= 1'b1;
							state     <= i2cib_pkg::MON_IDLE;
						end
					end
					default: state <= i2cib_pkg::MON_IDLE;
				endcase
			end
		end
	end

	assign sync_wait = (state != i2cib_pkg::MON_IDLE);

endmodule

// file: i2cib_core_sva.sv
`timescale 1ns/1ps
module i2cib_core_sva (
	input wire logic       clk,             // Clock
	input wire logic       rst,             // Reset
	input wire logic [3:0] reg_addr,        // Index
	input wire logic [7:0] reg_wdata,       // Write data
	input wire logic       reg_wr,          // Write strobe
	input wire logic       reg_rd,          // Read strobe
	input wire logic       eng_shift_take,  // Shifter take
	input wire logic       eng_tx_done,     // Byte sent
	input wire logic       eng_rx_done,     // Byte received
	input wire logic       eng_eighth_fall, // Eighth fall
	input wire logic       tx_data_valid,   // Byte waiting
	input wire logic       master_select,   // Master
	input wire logic       transmit_select, // Transmit
	input wire logic       i2c_mode,        // Mode
	input wire logic       scl_high_seen,   // Monitor pulse
	input wire logic       scl_oe,          // SCL pull
	input wire logic       tx_empty_irq,    // Request
	input wire logic       tx_end_irq,      // Request
	input wire logic       rx_full_irq,     // Request
	input wire logic       stop_seen_irq    // Request
);
	logic [1:0] rate;
	logic [5:0] since;
	logic [5:0] least;
	logic       tx_wr;
	logic       rx_rd;
	logic       rx_drop;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	assign tx_wr = reg_wr && reg_addr == i2cib_pkg::REG_TX_DATA;
	assign rx_rd = reg_rd && reg_addr == i2cib_pkg::REG_RX_DATA;
	assign rx_drop = rx_rd || reg_wr && (reg_addr == i2cib_pkg::REG_STATUS
		|| reg_addr == i2cib_pkg::REG_IRQ_EN);
	// Half-cycle monitor times taken as the next whole cycle
	assign least = rate[1] ? (rate[0] ? 6'h2A : 6'h12)
		: (rate[0] ? 6'h14 : 6'h08);
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rate <= 2'h0;
		else if (reg_wr && reg_addr == i2cib_pkg::REG_CTRL)
			rate <= reg_wdata[3:2];
	end
	// Saturates so a long idle never wraps into a false short delay
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			since <= 6'h00;
		else if ($fell(scl_oe) && master_select)
			since <= 6'h01;
		else if (since != 6'h3F)
			since <= since + 6'h01;
	end
	a_txwr_clear: assert property (
		tx_wr && !eng_shift_take && !eng_tx_done
		|=> !tx_empty_irq && !tx_end_irq) else $error("tx flags kept");
	a_txwr_valid: assert property (
		tx_wr |=> tx_data_valid) else $error("write not pending");
	a_take_empty: assert property (
		tx_data_valid && eng_shift_take && !tx_wr |=> !tx_data_valid)
		else $error("byte not moved on");
	a_rxrd_clear: assert property (
		rx_rd && !eng_rx_done |=> !rx_full_irq) else $error("rx full kept");
	a_rxfull_level: assert property (
		$fell(rx_full_irq) |-> $past(rx_drop))
		else $error("rx request dropped by itself");
	a_hold_low: assert property (
		rx_full_irq && master_select && !transmit_select && i2c_mode
		&& eng_eighth_fall && !rx_rd |=> scl_oe) else $error("no hold");
	a_mon_delay: assert property (
		scl_high_seen |-> since >= least) else $error("SCL sampled early");
	a_sync_stop: assert property (
		!i2c_mode |-> !stop_seen_irq) else $error("stop in sync mode");
endmodule
bind i2cib_core i2cib_core_sva i2cib_core_sva_i (.clk, .rst, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .eng_shift_take, .eng_tx_done,
	.eng_rx_done, .eng_eighth_fall, .tx_data_valid, .master_select,
	.transmit_select, .i2c_mode, .scl_high_seen, .scl_oe, .tx_empty_irq,
	.tx_end_irq, .rx_full_irq, .stop_seen_irq);

// file: i2cib_peer.sv
`timescale 1ns/1ps
module i2cib_peer (
	input  wire logic       scl_oe,   // Device pulls SCL low
	input  wire logic [3:0] stretch,  // Link periods held low
	output logic            scl_line  // Wire level
);
	logic hold = 1'h0;
	logic link_clk = 1'h0;
	// Pull-up wins only when nobody pulls the line low
	assign scl_line = !(scl_oe || hold);
	// A slow slave stretches; its clock runs only inside that frame
	always @(negedge scl_oe) begin
		if (stretch != 4'h0) begin
			hold = 1'h1;
			repeat (2 * stretch) #62.5 link_clk = ~link_clk;
			// Let go between system clock edges, never on one
			#1;
			hold = 1'h0;
		end
	end
endmodule

// file: tb_i2cib_core.sv
`timescale 1ns/1ps
module tb_i2cib_core;
	logic       clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
	logic [3:0] reg_addr = 4'h0, stretch = 4'h0;
	logic [7:0] reg_wdata = 8'h00, eng_rx_byte = 8'h00, ev = 8'h00;
	logic       eng_scl_low = 1'h0, scl_in, scl_out, scl_oe, irq;
	logic [7:0] reg_rdata, tx_shift_data;
	logic       eng_shift_take, eng_tx_done, eng_rx_done, eng_eighth_fall;
	logic       eng_eighth_rise, eng_nack, eng_stop, eng_arb_lost;
	logic       tx_data_valid, master_select, transmit_select, i2c_mode;
	logic       single_byte_receive_ctrl, scl_high_seen, scl_sync_wait;
	logic       tx_empty_irq, tx_end_irq, rx_full_irq, stop_seen_irq;
	logic       nack_irq;
	int         fail_count = 0, n_tests = 0, n;
	int         least[4] = '{8, 20, 18, 42};
	assign {eng_arb_lost, eng_stop, eng_nack, eng_eighth_rise,
		eng_eighth_fall, eng_rx_done, eng_tx_done, eng_shift_take} = ev;
	i2cib_core i2cib_core_i (.*);
	i2cib_peer i2cib_peer_i (.scl_oe(scl_oe), .stretch(stretch),
		.scl_line(scl_in));
	always #5 clk = ~clk;
	task automatic results();
		if (fail_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'h0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		chk(reg_rdata, e);
	endtask
	task automatic pulse(input logic [7:0] p);
		@(posedge clk);
		ev <= p;
		@(posedge clk);
		ev <= 8'h00;
		#1;
	endtask
	// Release SCL and count cycles until the monitor reports it high
	task automatic sync(input int lo, input int hi);
		@(posedge clk);
		eng_scl_low <= 1'h1;
		@(posedge clk);
		eng_scl_low <= 1'h0;
		n = 0;
		while (scl_high_seen !== 1'h1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
			if (n == 2)
				chk({7'h0, scl_sync_wait}, 8'h01);
		end
		chk(8'(n >= lo && n <= hi), 8'h01);
		chk({7'h0, scl_sync_wait}, 8'h00);
		if (n == 200)
			results();
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		rd(i2cib_pkg::REG_MODE, 8'h01);
		rd(4'hF, 8'h00);
		rd(i2cib_pkg::REG_CTRL2, 8'h01);
		wr(i2cib_pkg::REG_IRQ_EN, 8'h3F);
		wr(i2cib_pkg::REG_EVT_MASK, 8'h1F);
		wr(i2cib_pkg::REG_TX_DATA, 8'hA5);
		chk({6'h0, tx_empty_irq, tx_data_valid}, 8'h01);
		pulse(8'h01);
		chk(tx_shift_data, 8'hA5);
		chk({7'h0, tx_empty_irq}, 8'h01);
		pulse(8'h02);
		chk({6'h0, tx_end_irq, tx_empty_irq}, 8'h03);
		rd(i2cib_pkg::REG_EVT_STAT, 8'h03);
		chk({7'h0, irq}, 8'h00);
		wr(i2cib_pkg::REG_TX_DATA, 8'h5A);
		chk({6'h0, tx_end_irq, tx_empty_irq}, 8'h00);
		wr(i2cib_pkg::REG_EVT_MASK, 8'h00);
		pulse(8'h01);
		chk({7'h0, irq}, 8'h00);
		wr(i2cib_pkg::REG_EVT_MASK, 8'h1F);
		chk({7'h0, irq}, 8'h01);
		rd(i2cib_pkg::REG_EVT_STAT, 8'h01);
		chk({7'h0, irq}, 8'h00);
		wr(i2cib_pkg::REG_CTRL, 8'h01);
		eng_rx_byte <= 8'h3C;
		pulse(8'h04);
		chk({7'h0, rx_full_irq}, 8'h01);
		pulse(8'h08);
		repeat (3) @(posedge clk);
		#1;
		chk({7'h0, scl_oe}, 8'h01);
		rd(i2cib_pkg::REG_RX_DATA, 8'h3C);
		@(posedge clk);
		#1;
		chk({6'h0, rx_full_irq, scl_oe}, 8'h00);
		wr(i2cib_pkg::REG_MODE, 8'h00);
		pulse(8'h60);
		chk({6'h0, nack_irq, stop_seen_irq}, 8'h00);
		eng_rx_byte <= 8'h11;
		pulse(8'h04);
		pulse(8'h10);
		chk({7'h0, nack_irq}, 8'h01);
		eng_rx_byte <= 8'h22;
		pulse(8'h04);
		rd(i2cib_pkg::REG_RX_DATA, 8'h11);
		wr(i2cib_pkg::REG_STATUS, 8'h01);
		wr(i2cib_pkg::REG_MODE, 8'h01);
		chk({6'h0, nack_irq, stop_seen_irq}, 8'h00);
		pulse(8'h60);
		chk({6'h0, nack_irq, stop_seen_irq}, 8'h03);
		pulse(8'h80);
		chk({6'h0, master_select, transmit_select}, 8'h00);
		for (int r = 0; r < 4; r++) begin
			wr(i2cib_pkg::REG_CTRL, 8'(r << 2) | 8'h01);
			sync(least[r], least[r] + 5);
		end
		wr(i2cib_pkg::REG_CTRL, 8'h01);
		stretch <= 4'h2;
		sync(27, 32);
		wr(i2cib_pkg::REG_CTRL, 8'h10);
		chk({6'h0, single_byte_receive_ctrl, scl_out}, 8'h02);
		results();
	end
endmodule
